// File: rtl/sar_consts.svh
// constants for the sar conversion sequencer: timing, widths and counts
// assumes the reference clock runs at the rate given by sar_ref_clk_khz
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// reference clock rate in khz (40 mhz)
`define SAR_REF_CLK_KHZ       40000
// conversion clock limits in khz
`define SAR_CONV_CLK_MIN_KHZ  1000
`define SAR_CONV_CLK_MAX_KHZ  18000
// conversion clocks per sample
`define SAR_CLKS_PER_SAMPLE   18
// conversion clocks spent tracking the input
`define SAR_SAMPLE_TICKS      5
// result width and result buffer depth
`define SAR_RESULT_BITS       12
`define SAR_FIFO_DEPTH        16
// default reference-clock divider for the conversion clock (10 mhz)
`define SAR_CONV_DIV_DEFAULT  4
// power-up / wake wait in ns
`define SAR_PWRUP_WAIT_NS     10000

`endif

// File: rtl/sar_pkg.sv
// types shared by the sar conversion sequencer
// assumes nothing of its surroundings
package sar_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    st_power_wait = 3'h0,
    st_idle       = 3'h1,
    st_sample     = 3'h2,
    st_bits       = 3'h3,
    st_finish     = 3'h4
  } sar_state_type;

endpackage

// File: rtl/sample_fifo.sv
// result buffer: first-word-fall-through fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "sar_consts.svh"
module sample_fifo #(
  parameter int WIDTH = `SAR_RESULT_BITS,
  parameter int DEPTH = `SAR_FIFO_DEPTH
) (
  input  wire logic             ref_clk_in,    // clock
  input  wire logic             nrst_in,       // async reset, low
  input  wire logic             in_valid_in,   // write request
  output logic                  in_ready_out,  // room for a word
  input  wire logic [WIDTH-1:0] in_data_in,    // write data
  output logic                  out_valid_out, // word available
  input  wire logic             out_ready_in,  // reader takes word
  output logic [WIDTH-1:0]      out_data_out   // head word
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] rd_next;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  // pointer advance with wrap for any depth
  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // handshakes and occupancy
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  assign rd_next = pop ? next_ptr(rd_ptr) : rd_ptr;
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // storage write
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers, count and registered flags
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= next_ptr(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= next_ptr(rd_ptr);
      end
      count         <= next_count;
      in_ready_out  <= (next_count != CNT_W'(DEPTH));
      out_valid_out <= (next_count != '0);
    end
  end

  // registered head word; the incoming word is taken when it becomes the head
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_data_out <= '0;
    end else if (push && (wr_ptr == rd_next)) begin
      out_data_out <= in_data_in;
    end else begin
      out_data_out <= mem[rd_next];
    end
  end
endmodule

// File: rtl/sar_adc_conversion_control.sv
// sar adc conversion sequencer: power-up wait, triggering, bit search,
// result buffering and completion signalling
// assumes a comparator input from the analog side and a reader (dma or cpu)
// that drains results with valid/ready; control inputs are on ref_clk_in
//
// Function
// - conversion clock is eighteen per sample, 1-18 mhz; the divider range of 3 to 40 gives 1 to about 13.3 mhz
// - software start or frame trigger begins conversion
// - wait 10 us after power-up or wake
// - completion sets a status bit for software
// - done output holds until result is read
// - done output usable as interrupt or dma request
// - select continuous or one conversion per trigger
// - continuous results drain by dma without cpu
// - twelve-bit result, up to one msps; the minimum divider of 3 limits this to about 741 ksps
// - bits decided msb first by binary search
`timescale 1ns/1ps
`include "sar_consts.svh"
module sar_adc_conversion_control #(
  parameter int CONV_DIV    = `SAR_CONV_DIV_DEFAULT,
  parameter int RESULT_BITS = `SAR_RESULT_BITS,
  parameter int FIFO_DEPTH  = `SAR_FIFO_DEPTH
) (
  input  wire logic                   ref_clk_in,                  // 40 mhz clock
  input  wire logic                   nrst_in,                     // async reset, low
  input  wire logic                   conv_enable_in,              // converter powered
  input  wire logic                   single_conversion_select_in, // 1: one per trigger
  input  wire logic                   start_in,                    // software start pulse
  input  wire logic                   frame_start_in,              // external trigger pin
  input  wire logic                   comp_in,                     // comparator, async
  input  wire logic                   status_clear_in,             // clears status bit
  input  wire logic                   result_ready_in,             // reader takes result
  output logic [RESULT_BITS-1:0]      result_data_out,             // oldest result
  output logic                        result_valid_out,            // result waiting
  output logic                        conv_done_out,               // done, held till read
  output logic                        status_done_out,             // sticky completion
  output logic [RESULT_BITS-1:0]      dac_code_out,                // search dac code
  output logic                        sample_out,                  // track phase
  output logic                        conv_clk_out,                // conversion clock
  output logic                        ready_out,                   // power-up wait over
  output logic                        busy_out                     // conversion running
);
  // conversion clock divider limits derived from the rate bounds
  localparam int DIV_MIN = (`SAR_REF_CLK_KHZ + `SAR_CONV_CLK_MAX_KHZ - 1)
                           / `SAR_CONV_CLK_MAX_KHZ;
  localparam int DIV_MAX = `SAR_REF_CLK_KHZ / `SAR_CONV_CLK_MIN_KHZ;
  localparam int DIV_EFF = (CONV_DIV < DIV_MIN) ? DIV_MIN :
                           ((CONV_DIV > DIV_MAX) ? DIV_MAX : CONV_DIV);
  localparam int DIV_W   = $clog2(DIV_MAX + 1);
  localparam int HALF    = DIV_EFF / 2;
  // power-up wait rounded up to whole reference cycles
  localparam int PWRUP_CYCLES = (`SAR_PWRUP_WAIT_NS * `SAR_REF_CLK_KHZ + 999999)
                                / 1000000;
  localparam int PWR_W   = $clog2(PWRUP_CYCLES + 1);
  localparam int IDX_W   = $clog2(RESULT_BITS);
  localparam int SMP_W   = $clog2(`SAR_SAMPLE_TICKS + 1);

  sar_pkg::sar_state_type state;
  logic [DIV_W-1:0]       div_cnt;
  logic                   tick;
  logic [PWR_W-1:0]       pwr_cnt;
  logic [SMP_W-1:0]       smp_cnt;
  logic [IDX_W-1:0]       bit_idx;
  logic                   fs_meta;
  logic                   fs_sync;
  logic                   fs_prev;
  logic                   fs_rise;
  logic                   comp_meta;
  logic                   comp_sync;
  logic                   trig_pend;
  logic                   cont_run;
  logic                   launch;
  logic                   last_bit;
  logic                   wr_valid;
  logic [RESULT_BITS-1:0] wr_data;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [RESULT_BITS-1:0] next_code;

  // one search step: keep or drop the bit under test, raise the next one
  function automatic logic [RESULT_BITS-1:0] search_step(
    input logic [RESULT_BITS-1:0] code,
    input logic [IDX_W-1:0]       idx,
    input logic                   keep
  );
    logic [RESULT_BITS-1:0] c;
    c = code;
    c[idx] = keep;
    if (idx != '0) begin
      c[idx - 1'b1] = 1'b1;
    end
    search_step = c;
  endfunction

  // two-flop synchronisers for the trigger pin and comparator
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fs_meta   <= 1'b0;
      fs_sync   <= 1'b0;
      fs_prev   <= 1'b0;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      fs_meta   <= frame_start_in;
      fs_sync   <= fs_meta;
      fs_prev   <= fs_sync;
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  assign fs_rise = fs_sync & ~fs_prev;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt      <= '0;
      conv_clk_out <= 1'b0;
    end else if (!conv_enable_in) begin
      div_cnt      <= '0;
      conv_clk_out <= 1'b0;
    end else begin
      if (tick) begin
        div_cnt      <= '0;
        conv_clk_out <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 1'b1;
        if (div_cnt == DIV_W'(HALF - 1)) begin
          conv_clk_out <= 1'b0;
        end
      end
    end
  end
  assign tick = (div_cnt == DIV_W'(DIV_EFF - 1));

  // power-up wait counter, rearmed by disable
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_cnt   <= '0;
      ready_out <= 1'b0;
    end else if (!conv_enable_in) begin
      pwr_cnt   <= '0;
      ready_out <= 1'b0;
    end else if (pwr_cnt != PWR_W'(PWRUP_CYCLES)) begin
      pwr_cnt   <= pwr_cnt + 1'b1;
      ready_out <= (pwr_cnt == PWR_W'(PWRUP_CYCLES - 1));
    end
  end

  // pending trigger, new request wins over consumption
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_pend <= 1'b0;
    end else if (!conv_enable_in) begin
      trig_pend <= 1'b0;
    end else begin
      trig_pend <= start_in | fs_rise | (trig_pend & ~launch);
    end
  end

  // continuous run flag, dropped by single select
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cont_run <= 1'b0;
    end else if (!conv_enable_in || single_conversion_select_in) begin
      cont_run <= 1'b0;
    end else if (start_in || fs_rise) begin
      cont_run <= 1'b1;
    end
  end

  // continuous running needs no further triggers
  assign launch   = (state == sar_pkg::st_idle) && tick && fifo_in_ready
                    && (trig_pend || cont_run);
  assign last_bit = (bit_idx == '0);
  assign next_code = search_step(dac_code_out, bit_idx, comp_sync);

  // sequencer: eighteen conversion clocks per sample
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state        <= sar_pkg::st_power_wait;
      smp_cnt      <= '0;
      bit_idx      <= '0;
      dac_code_out <= '0;
      sample_out   <= 1'b0;
      busy_out     <= 1'b0;
    end else if (!conv_enable_in) begin
      state      <= sar_pkg::st_power_wait;
      sample_out <= 1'b0;
      busy_out   <= 1'b0;
    end else begin
      case (state)
        sar_pkg::st_power_wait: begin
          if (ready_out) begin
            state <= sar_pkg::st_idle;
          end
        end
        sar_pkg::st_idle: begin
          if (launch) begin
            state      <= sar_pkg::st_sample;
            smp_cnt    <= '0;
            sample_out <= 1'b1;
            busy_out   <= 1'b1;
          end
        end
        sar_pkg::st_sample: begin
          if (tick) begin
            smp_cnt <= smp_cnt + 1'b1;
            if (smp_cnt == SMP_W'(`SAR_SAMPLE_TICKS - 1)) begin
              state        <= sar_pkg::st_bits;
              sample_out   <= 1'b0;
              bit_idx      <= IDX_W'(RESULT_BITS - 1);
              dac_code_out <= {1'b1, {(RESULT_BITS - 1){1'b0}}};
            end
          end
        end
        sar_pkg::st_bits: begin
          if (tick) begin
            dac_code_out <= next_code;
            bit_idx      <= bit_idx - 1'b1;
            if (last_bit) begin
              state <= sar_pkg::st_finish;
            end
          end
        end
        sar_pkg::st_finish: begin
          if (tick) begin
            if (cont_run && fifo_in_ready) begin
              state      <= sar_pkg::st_sample;
              smp_cnt    <= '0;
              sample_out <= 1'b1;
            end else begin
              state    <= sar_pkg::st_idle;
              busy_out <= 1'b0;
            end
          end
        end
        default: begin
          state      <= sar_pkg::st_power_wait;
          sample_out <= 1'b0;
          busy_out   <= 1'b0;
        end
      endcase
    end
  end

  // twelve-bit result into the buffer, held until accepted
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else if (state == sar_pkg::st_bits && tick && last_bit) begin
      wr_valid <= 1'b1;
      wr_data  <= next_code;
    end else if (fifo_in_ready) begin
      wr_valid <= 1'b0;
    end
  end

  // sticky completion status, completion wins over clear
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_done_out <= 1'b0;
    end else if (state == sar_pkg::st_bits && tick && last_bit) begin
      status_done_out <= 1'b1;
    end else if (status_clear_in) begin
      status_done_out <= 1'b0;
    end
  end

  // results drain by handshake, no cpu needed
  sample_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (wr_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (wr_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (result_ready_in),
    .out_data_out  (result_data_out)
  );

  // level usable as irq or dma request
  assign conv_done_out    = fifo_out_valid;
  assign result_valid_out = fifo_out_valid;
endmodule

// File: verif/sar_checker_asserts.sv
// port checker for the sar conversion sequencer
// assumes one clock, a 400-cycle wake wait and the default divider
`timescale 1ns/1ps
module sar_checker #(
  parameter int CONV_DIV    = 4,
  parameter int RESULT_BITS = 12,
  parameter int FIFO_DEPTH  = 16
) (
  input wire logic                   ref_clk_in,                  // clock
  input wire logic                   nrst_in,                     // reset, low
  input wire logic                   conv_enable_in,              // awake
  input wire logic                   single_conversion_select_in, // single
  input wire logic                   start_in,                    // start
  input wire logic                   frame_start_in,              // trigger
  input wire logic                   comp_in,                     // comparator
  input wire logic                   status_clear_in,             // clear
  input wire logic                   result_ready_in,             // read
  input wire logic [RESULT_BITS-1:0] result_data_out,             // result
  input wire logic                   result_valid_out,            // waiting
  input wire logic                   conv_done_out,               // done
  input wire logic                   status_done_out,             // status
  input wire logic [RESULT_BITS-1:0] dac_code_out,                // dac code
  input wire logic                   sample_out,                  // track
  input wire logic                   conv_clk_out,                // conv clock
  input wire logic                   ready_out,                   // awake
  input wire logic                   busy_out                     // running
);
  localparam int SAMP_M1 = 5 * CONV_DIV - 1;
  localparam logic [RESULT_BITS-1:0] MSB_CODE = {1'b1, {(RESULT_BITS-1){1'b0}}};
  logic [8:0] en_cnt; // awake cycles, saturating
  logic [5:0] ck_cnt; // cycles since conv clock rose, 0 = unknown
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // counts awake cycles for the wake wait
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_cnt <= '0;
    end else if (!conv_enable_in) begin
      en_cnt <= '0;
    end else if (en_cnt != 9'h1ff) begin
      en_cnt <= en_cnt + 9'h001;
    end
  end
  // measures the conversion clock period
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ck_cnt <= '0;
    end else if (!conv_enable_in) begin
      ck_cnt <= '0;
    end else if ($rose(conv_clk_out)) begin
      ck_cnt <= 6'h01;
    end else if (ck_cnt != 6'h00 && ck_cnt != 6'h3f) begin
      ck_cnt <= ck_cnt + 6'h01;
    end
  end
  // track phase lasts five conversion clocks
  sequence s_track;
    ##SAMP_M1 sample_out ##1 !sample_out;
  endsequence
  a_done_is_valid: assert property (conv_done_out == result_valid_out)
    else $error("done differs from result waiting");
  a_done_held: assert property (conv_done_out && !result_ready_in |=> conv_done_out)
    else $error("done dropped before read");
  a_wake_wait: assert property ($rose(ready_out) |-> en_cnt inside {[400:401]})
    else $error("ready rose at wrong time");
  a_no_early_conv: assert property (!ready_out |-> !sample_out)
    else $error("conversion before wake wait");
  a_sleep_drop: assert property (!conv_enable_in |-> ##[1:2] !ready_out)
    else $error("ready kept in sleep");
  a_clk_period: assert property ($rose(conv_clk_out) && ck_cnt != 6'h00
                                 |-> ck_cnt == CONV_DIV)
    else $error("conversion clock period wrong");
  a_track_len: assert property ($rose(sample_out) |-> s_track)
    else $error("track phase length wrong");
  a_msb_first: assert property ($fell(sample_out) |-> ##[0:1] dac_code_out == MSB_CODE)
    else $error("search not started at msb");
  a_status_set: assert property ($rose(result_valid_out) |-> status_done_out)
    else $error("status not set on completion");
  a_status_sticky: assert property (status_done_out && !status_clear_in
                                    |=> status_done_out)
    else $error("status lost without clear");
  a_track_busy: assert property (sample_out |-> busy_out)
    else $error("track while not busy");
endmodule
bind sar_adc_conversion_control sar_checker #(.CONV_DIV(CONV_DIV),
  .RESULT_BITS(RESULT_BITS), .FIFO_DEPTH(FIFO_DEPTH)) sar_checker_i (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .conv_enable_in(conv_enable_in),
  .single_conversion_select_in(single_conversion_select_in), .start_in(start_in),
  .frame_start_in(frame_start_in), .comp_in(comp_in), .status_clear_in(status_clear_in),
  .result_ready_in(result_ready_in), .result_data_out(result_data_out),
  .result_valid_out(result_valid_out), .conv_done_out(conv_done_out),
  .status_done_out(status_done_out), .dac_code_out(dac_code_out),
  .sample_out(sample_out), .conv_clk_out(conv_clk_out), .ready_out(ready_out),
  .busy_out(busy_out));

// File: verif/result_reader.sv
// far side: result reader with a slow ready, and the comparator
// assumes valid/ready reads; comparator keeps a bit while level >= code
`timescale 1ns/1ps
module result_reader (
  input  wire logic        ref_clk_in,  // clock
  input  wire logic        nrst_in,     // reset, low
  input  wire logic        take_in,     // drain enable
  input  wire logic [11:0] target_in,   // input level as a code
  input  wire logic [11:0] dac_code_in, // search dac code
  input  wire logic        valid_in,    // result waiting
  input  wire logic [11:0] data_in,     // head result
  output logic             ready_out,   // takes head result
  output logic             comp_out,    // comparator
  output logic [11:0]      last_out,    // last word taken
  output int               count_out    // words taken
);
  logic stall; // reader takes every other cycle
  // comparator against the search code
  assign comp_out = target_in >= dac_code_in;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall <= 1'b0;
      ready_out <= 1'b0;
      last_out <= '0;
      count_out <= 0;
    end else begin
      stall <= ~stall;
      ready_out <= take_in & stall;
      if (valid_in && ready_out) begin
        last_out <= data_in;
        count_out <= count_out + 1;
      end
    end
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the sar conversion sequencer
// assumes divider 4 (72 cycles a sample) and a 400-cycle wake wait
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0, nrst_in = 1'b0, en = 1'b0, single = 1'b1;
  logic start = 1'b0, frame = 1'b0, clr = 1'b0, take = 1'b0, rdy, comp;
  logic [11:0] target = 12'h0000, data, dac, last;
  logic valid, done, status, track, cclk, awake, busy;
  int n_fail = 0, check_count = 0, seed = 32'h7b8a_c7d1, cnt, i;
  // 40 mhz clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  sar_adc_conversion_control #(.CONV_DIV(4)) sar_adc_conversion_control_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .conv_enable_in(en),
    .single_conversion_select_in(single), .start_in(start), .frame_start_in(frame),
    .comp_in(comp), .status_clear_in(clr), .result_ready_in(rdy),
    .result_data_out(data), .result_valid_out(valid), .conv_done_out(done),
    .status_done_out(status), .dac_code_out(dac), .sample_out(track),
    .conv_clk_out(cclk), .ready_out(awake), .busy_out(busy));
  result_reader result_reader_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .take_in(take), .target_in(target), .dac_code_in(dac), .valid_in(valid),
    .data_in(data), .ready_out(rdy), .comp_out(comp), .last_out(last), .count_out(cnt));
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for a waiting result, or for n words taken
  task automatic wait_for(input string what, input int words, input int lim);
    while (lim > 0 && (words < 0 ? valid !== 1'b1 : cnt < words)) begin
      step(1);
      lim--;
    end
    if (words < 0 ? valid !== 1'b1 : cnt < words) begin
      n_fail++;
      $display("ERROR %s expected event seen timeout", what);
      end_of_test();
    end
  endtask
  task automatic pulse_trigger(input bit use_frame);
    @(posedge ref_clk_in);
    if (use_frame) frame <= 1'b1;
    else start <= 1'b1;
    // software start is a single-cycle request; the pin is held for the synchroniser
    @(posedge ref_clk_in);
    start <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    frame <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    en <= 1'b1;
    step(1);
    chk_bit("busy after reset", 1'b0, busy);
    pulse_trigger(0);
    step(380);
    chk_bit("ready early", 1'b0, awake);
    chk_bit("result early", 1'b0, valid);
    step(20);
    chk_bit("ready", 1'b1, awake);
    $display("done: wake wait");
    for (i = 0; i < 8; i++) begin
      if (i > 0) target <= (i == 1) ? 12'h0fff : (i == 2) ? 12'h0800 : 12'($random(seed));
      if (i > 0) pulse_trigger(i[0]);
      wait_for("result", -1, 300);
      chk_bit("status", 1'b1, status);
      step(40);
      chk_bit("done held", 1'b1, done);
      take <= 1'b1;
      wait_for("read", i + 1, 50);
      take <= 1'b0;
      chk_word("result", target, last);
      step(3);
      chk_bit("done after read", 1'b0, done);
      step(150);
      chk_bit("one per trigger", 1'b0, valid);
      chk_bit("idle", 1'b0, busy);
      @(posedge ref_clk_in);
      clr <= 1'b1;
      step(1);
      clr <= 1'b0;
      step(1);
      chk_bit("status cleared", 1'b0, status);
    end
    $display("done: single conversions");
    target <= 12'($random(seed));
    single <= 1'b0;
    pulse_trigger(0);
    step(16 * 72 + 300);
    chk_bit("fifo full held", 1'b1, done);
    chk_word("head", target, data);
    single <= 1'b1;
    take <= 1'b1;
    wait_for("drain", 8 + 16, 800);
    chk_word("drained", target, last);
    step(300);
    chk_bit("drained empty", 1'b0, valid);
    take <= 1'b0;
    $display("done: continuous");
    en <= 1'b0;
    step(3);
    chk_bit("sleep ready", 1'b0, awake);
    en <= 1'b1;
    step(390);
    chk_bit("wake early", 1'b0, awake);
    step(20);
    chk_bit("wake", 1'b1, awake);
    $display("done: sleep");
    end_of_test();
  end
endmodule
